// >>> common/fga_pkg.sv
// Shared constants and types for the fail output and general pin block.
package fga_pkg;

	// Clock and pattern timing; periods in ns, counts derived in cycles.
	localparam int CLK_PERIOD_NS = 10;
	localparam int BLINK_PERIOD_NS = 800_000_000;
	localparam int PWM_PERIOD_NS = 10_000_000;
	localparam int STRAP_FILTER_NS = 64_000;
	localparam int BLINK_PERIOD_CYC = BLINK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
	localparam int STRAP_FILTER_CYC =
		(STRAP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLINK_DUTY_DIV = 2;
	localparam int CNT_W = 27;

	// Duty select codes: 20, 10, 5 and 2.5 percent of the PWM period.
	localparam int DUTY_W = 2;
	localparam logic [DUTY_W-1:0] DUTY_RST = 2'h0;
	localparam int DUTY_DIV_20 = 5;
	localparam int DUTY_DIV_10 = 10;
	localparam int DUTY_DIV_5 = 20;
	localparam int DUTY_DIV_2P5 = 40;

	// Avalon word addresses of the registers.
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] REG_CFG = 3'h0;
	localparam logic [ADDR_W-1:0] REG_DUTY = 3'h1;
	localparam logic [ADDR_W-1:0] REG_WAKE = 3'h2;
	localparam logic [ADDR_W-1:0] REG_LVL = 3'h3;
	localparam logic [ADDR_W-1:0] REG_STAT = 3'h4;

	// Field positions.
	localparam int FN_W = 3;
	localparam int CFG_A_LSB = 0;
	localparam int CFG_B_LSB = 4;
	localparam int DUTY_LSB = 0;
	localparam int PIN_A_BIT = 0;
	localparam int PIN_B_BIT = 1;
	localparam int STAT_FAIL_BIT = 0;
	localparam int STAT_STRAP_BIT = 1;

	typedef enum logic [2:0]
	{
		MODE_NORMAL = 3'h0,
		MODE_STOP = 3'h1,
		MODE_SLEEP = 3'h3,
		MODE_RESTART = 3'h2,
		MODE_FAILSAFE = 3'h6
	} fga_mode_e;

	typedef enum logic [FN_W-1:0]
	{
		FN_FAIL = 3'h0,
		FN_OFF = 3'h1,
		FN_WAKE = 3'h3,
		FN_LS = 3'h2,
		FN_HS = 3'h6
	} fga_fn_e;

	localparam logic [FN_W-1:0] FN_RST = 3'h0;
	localparam logic STRAP_RST = 1'b1;

endpackage

// >>> src/fga_pattern_gen.sv
// Free-running period counter producing a registered on-phase flag.
`timescale 1ns/10ps
module fga_pattern_gen
	import fga_pkg::*;
#(
	parameter int unsigned PERIOD = 100
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic restart,
	input wire logic [CNT_W-1:0] high_cyc,
	output logic on_r
);

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;

	always_comb
	begin
		if (restart || cnt_r == CNT_W'(PERIOD - 1))
			cnt_nxt = '0;
		else
			cnt_nxt = cnt_r + CNT_W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	// The on phase opens each period, so a restart shows it at once.
	always_ff @(posedge clk)
	begin
		if (rst)
			on_r <= 1'b0;
		else
			on_r <= (cnt_nxt < high_cyc);
	end

endmodule

// >>> src/fga_top.sv
// Fail output pins with general pin alternate functions and register slave.
//
// Function
// - Both pins reset to fail output function.
// - Functions: fail, off, wake, low-side, high-side.
// - Wake input latches events into wake status.
// - Normal/stop show live level for input/switch.
// - Pin b level shares the strap level bit.
// - Function changes accepted only in normal mode.
// - Stop and sleep keep configured pin function.
// - Wake stays in restart, off in fail-safe.
// - Switches off in restart/fail-safe, then resume.
// - Fail output stays active through restart into normal.
// - Off pins stay inactive in every mode.
// - Switches report no diagnostic status at all.
// - Pin a blinks 1.25 Hz, half duty.
// - Pin b PWM 100 Hz, default 20 percent.
// - Strap input filtered for 64 us.
// - Static and shared fail outputs activate together.
// - PWM duty selectable 20, 10, 5, 2.5 percent.
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module fga_top
	import fga_pkg::*;
#(
	parameter int unsigned BLINK_CYC = BLINK_PERIOD_CYC,
	parameter int unsigned PWM_CYC = PWM_PERIOD_CYC,
	parameter int unsigned STRAP_CYC = STRAP_FILTER_CYC
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [2:0] chip_mode,
	input wire logic fail_event,
	input wire logic fail_clear,
	input wire logic shared_fail_pin_a_in,
	output logic shared_fail_pin_a_out,
	output logic shared_fail_pin_a_oe_n,
	input wire logic shared_fail_pin_b_strap_in,
	output logic shared_fail_pin_b_strap_out,
	output logic shared_fail_pin_b_strap_oe_n,
	output logic static_fail_n,
	output logic wake_en_a,
	output logic wake_en_b,
	output logic strap_level
);

	logic wait_r;
	logic [31:0] rdata_r;
	logic [FN_W-1:0] cfg_a_r;
	logic [FN_W-1:0] cfg_b_r;
	logic [DUTY_W-1:0] pwm_duty_select_r;
	logic [1:0] wake_event_status_second_r;
	logic [1:0] wake_level_status;
	logic [1:0] prev_lvl_r;
	logic fail_active_r;
	logic fail_start;
	logic strap_level_r;
	logic [CNT_W-1:0] strap_cnt_r;
	logic blink_on;
	logic pwm_on;
	logic [CNT_W-1:0] pwm_high;
	logic wr_take;
	logic rd_take;
	logic normal_mode;
	logic switch_allowed;
	logic level_window;
	logic wake_cap_a;
	logic wake_cap_b;
	logic [1:0] wake_hit;
	logic [1:0] wake_clr;
	logic [1:0] pin_lvl;
	logic [1:0] drive_a;
	logic [1:0] drive_b;
	logic static_fail_r;
	logic wake_en_a_r;
	logic wake_en_b_r;
	logic pin_a_out_r;
	logic pin_a_oe_n_r;
	logic pin_b_out_r;
	logic pin_b_oe_n_r;

	// Drive value and enable for one pin: {out, oe_n}, oe_n low drives.
	function automatic logic [1:0] pin_drive(
		input logic [FN_W-1:0] fn,
		input logic fail_on,
		input logic sw_ok
	);
		logic [1:0] d;
		d = 2'h1;
		case (fn)
			FN_FAIL:
				d = fail_on ? 2'h0 : 2'h1;
			FN_LS:
				d = sw_ok ? 2'h0 : 2'h1;
			FN_HS:
				d = sw_ok ? 2'h2 : 2'h1;
			default:
				d = 2'h1;
		endcase
		return d;
	endfunction

	function automatic logic is_io_fn(input logic [FN_W-1:0] fn);
		return fn == FN_WAKE || fn == FN_LS || fn == FN_HS;
	endfunction

	assign wr_take = avs_write && !wait_r;
	assign rd_take = avs_read && wait_r;
	assign normal_mode = chip_mode == MODE_NORMAL;
	assign pin_lvl = {shared_fail_pin_b_strap_in, shared_fail_pin_a_in};

	always_comb
	begin
		case (chip_mode)
			MODE_NORMAL, MODE_STOP, MODE_SLEEP:
				switch_allowed = 1'b1;
			default:
				switch_allowed = 1'b0;
		endcase
	end

	always_comb
	begin
		case (chip_mode)
			MODE_NORMAL, MODE_STOP:
				level_window = 1'b1;
			default:
				level_window = 1'b0;
		endcase
	end

	// Wake capability holds in normal, stop and sleep; restart is added below.
	assign wake_cap_a = cfg_a_r == FN_WAKE && switch_allowed;
	assign wake_cap_b = cfg_b_r == FN_WAKE && switch_allowed;

	// Restart mode keeps wake capability but not the switches.
	always_comb
	begin
		wake_hit = 2'h0;
		if ((wake_cap_a || (cfg_a_r == FN_WAKE &&
			chip_mode == MODE_RESTART)) &&
			pin_lvl[PIN_A_BIT] != prev_lvl_r[PIN_A_BIT])
			wake_hit[PIN_A_BIT] = 1'b1;
		if ((wake_cap_b || (cfg_b_r == FN_WAKE &&
			chip_mode == MODE_RESTART)) &&
			pin_lvl[PIN_B_BIT] != prev_lvl_r[PIN_B_BIT])
			wake_hit[PIN_B_BIT] = 1'b1;
	end

	assign wake_clr = (wr_take && avs_address == REG_WAKE &&
		avs_byteenable[0]) ? avs_writedata[1:0] : 2'h0;

	// Live levels for input and switch functions, else 0 on pin a and the strap level on pin b.
	always_comb
	begin
		wake_level_status[PIN_A_BIT] = level_window &&
			is_io_fn(cfg_a_r) && pin_lvl[PIN_A_BIT];
		if (level_window && is_io_fn(cfg_b_r))
			wake_level_status[PIN_B_BIT] =
				pin_lvl[PIN_B_BIT];
		else
			wake_level_status[PIN_B_BIT] = strap_level_r;
	end

	always_comb
	begin
		case (pwm_duty_select_r)
			2'h0:
				pwm_high = CNT_W'(PWM_CYC / DUTY_DIV_20);
			2'h1:
				pwm_high = CNT_W'(PWM_CYC / DUTY_DIV_10);
			2'h2:
				pwm_high = CNT_W'(PWM_CYC / DUTY_DIV_5);
			default:
				pwm_high = CNT_W'(PWM_CYC / DUTY_DIV_2P5);
		endcase
	end

	assign drive_a = pin_drive(cfg_a_r, fail_active_r && blink_on,
		switch_allowed);
	assign drive_b = pin_drive(cfg_b_r, fail_active_r && pwm_on,
		switch_allowed);

	// Answer each access one cycle after it is seen.
	always_ff @(posedge clk)
	begin
		if (rst)
			wait_r <= 1'b1;
		else if ((avs_read || avs_write) && wait_r)
			wait_r <= 1'b0;
		else
			wait_r <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			rdata_r <= '0;
		else if (rd_take)
		begin
			rdata_r <= '0;
			case (avs_address)
				REG_CFG:
				begin
					rdata_r[CFG_A_LSB +: FN_W] <= cfg_a_r;
					rdata_r[CFG_B_LSB +: FN_W] <= cfg_b_r;
				end
				REG_DUTY:
					rdata_r[DUTY_LSB +: DUTY_W] <= pwm_duty_select_r;
				REG_WAKE:
					rdata_r[1:0] <= wake_event_status_second_r;
				REG_LVL:
					rdata_r[1:0] <= wake_level_status;
				REG_STAT:
				begin
					rdata_r[STAT_FAIL_BIT] <= fail_active_r;
					rdata_r[STAT_STRAP_BIT] <= strap_level_r;
				end
				default:
					rdata_r <= '0;
			endcase
		end
	end

	// Configuration is frozen outside normal mode; writes are dropped.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cfg_a_r <= FN_RST;
			cfg_b_r <= FN_RST;
		end
		else if (wr_take && avs_address == REG_CFG &&
			avs_byteenable[0] && normal_mode)
		begin
			cfg_a_r <= avs_writedata[CFG_A_LSB +: FN_W];
			cfg_b_r <= avs_writedata[CFG_B_LSB +: FN_W];
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			pwm_duty_select_r <= DUTY_RST;
		else if (wr_take && avs_address == REG_DUTY &&
			avs_byteenable[0])
			pwm_duty_select_r <= avs_writedata[DUTY_LSB +: DUTY_W];
	end

	// A new wake event in the clearing cycle survives the clear.
	always_ff @(posedge clk)
	begin
		if (rst)
			wake_event_status_second_r <= 2'h0;
		else
			wake_event_status_second_r <=
				(wake_event_status_second_r & ~wake_clr) | wake_hit;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			prev_lvl_r <= 2'h3;
		else
			prev_lvl_r <= pin_lvl;
	end

	// A failure that arrives with the clear keeps the outputs active.
	always_ff @(posedge clk)
	begin
		if (rst)
			fail_active_r <= 1'b0;
		else if (fail_event)
			fail_active_r <= 1'b1;
		else if (fail_clear)
			fail_active_r <= 1'b0;
	end

	// Restarting the patterns in the activation cycle lets the first on
	// phase reach the pins together with the static fail output.
	assign fail_start = fail_event && !fail_active_r;

	// The level must differ for the full filter time to be accepted.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			strap_cnt_r <= '0;
			strap_level_r <= STRAP_RST;
		end
		else if (pin_lvl[PIN_B_BIT] == strap_level_r)
			strap_cnt_r <= '0;
		else if (strap_cnt_r == CNT_W'(STRAP_CYC - 1))
		begin
			strap_cnt_r <= '0;
			strap_level_r <= pin_lvl[PIN_B_BIT];
		end
		else
			strap_cnt_r <= strap_cnt_r + CNT_W'(1);
	end

	fga_pattern_gen #(
		.PERIOD(BLINK_CYC)
	) u_blink (
		.clk(clk),
		.rst(rst),
		.restart(fail_start),
		.high_cyc(CNT_W'(BLINK_CYC / BLINK_DUTY_DIV)),
		.on_r(blink_on)
	);

	fga_pattern_gen #(
		.PERIOD(PWM_CYC)
	) u_pwm (
		.clk(clk),
		.rst(rst),
		.restart(fail_start),
		.high_cyc(pwm_high),
		.on_r(pwm_on)
	);

	// Switch drives are registered; no status is kept.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_a_out_r <= 1'b0;
			pin_a_oe_n_r <= 1'b1;
			pin_b_out_r <= 1'b0;
			pin_b_oe_n_r <= 1'b1;
		end
		else
		begin
			pin_a_out_r <= drive_a[1];
			pin_a_oe_n_r <= drive_a[0];
			pin_b_out_r <= drive_b[1];
			pin_b_oe_n_r <= drive_b[0];
		end
	end

	// Registered alongside the shared pins so all three move together.
	always_ff @(posedge clk)
	begin
		if (rst)
			static_fail_r <= 1'b1;
		else
			static_fail_r <= !fail_active_r;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wake_en_a_r <= 1'b0;
			wake_en_b_r <= 1'b0;
		end
		else
		begin
			wake_en_a_r <= cfg_a_r == FN_WAKE &&
				chip_mode != MODE_FAILSAFE &&
				(switch_allowed || chip_mode == MODE_RESTART);
			wake_en_b_r <= cfg_b_r == FN_WAKE &&
				chip_mode != MODE_FAILSAFE &&
				(switch_allowed || chip_mode == MODE_RESTART);
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign shared_fail_pin_a_out = pin_a_out_r;
	assign shared_fail_pin_a_oe_n = pin_a_oe_n_r;
	assign shared_fail_pin_b_strap_out = pin_b_out_r;
	assign shared_fail_pin_b_strap_oe_n = pin_b_oe_n_r;
	assign static_fail_n = static_fail_r;
	assign wake_en_a = wake_en_a_r;
	assign wake_en_b = wake_en_b_r;
	assign strap_level = strap_level_r;

endmodule

// >>> tb/fga_sva.sv
// Assertion checker for the fail output and general pin block.
`timescale 1ns/10ps
module fga_sva
	import fga_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [2:0] chip_mode,
	input wire logic fail_event,
	input wire logic fail_clear,
	input wire logic shared_fail_pin_a_out,
	input wire logic shared_fail_pin_a_oe_n,
	input wire logic shared_fail_pin_b_strap_out,
	input wire logic shared_fail_pin_b_strap_oe_n,
	input wire logic static_fail_n,
	input wire logic wake_en_a,
	input wire logic wake_en_b
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	chk_bus_answer: assert property
		((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered");
	chk_wait_single: assert property
		(!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	chk_read_hold: assert property
		(!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data changed without read");
	chk_fail_together: assert property
		(fail_event && static_fail_n |-> ##[1:2] !static_fail_n)
		else $error("static fail not raised");
	chk_fail_hold: assert property
		(!static_fail_n && !fail_clear && !$past(fail_clear) |=> !static_fail_n)
		else $error("fail output dropped without clear");
	chk_fail_clear: assert property
		(fail_clear && !fail_event && !static_fail_n |-> ##[1:2] static_fail_n)
		else $error("fail output not cleared");
	chk_wake_safe: assert property
		(chip_mode == MODE_FAILSAFE |=> !wake_en_a && !wake_en_b)
		else $error("wake capable in fail-safe");
	chk_wake_restart: assert property
		(chip_mode == MODE_RESTART && wake_en_a |=> wake_en_a)
		else $error("wake lost in restart");
	chk_switch_released: assert property
		((chip_mode == MODE_RESTART || chip_mode == MODE_FAILSAFE) |=>
		!(!shared_fail_pin_a_oe_n && shared_fail_pin_a_out) &&
		!(!shared_fail_pin_b_strap_oe_n && shared_fail_pin_b_strap_out))
		else $error("high-side drive in restart or fail-safe");
endmodule

bind fga_top fga_sva u_sva (.clk, .rst, .avs_read, .avs_write, .avs_readdata,
	.avs_waitrequest, .chip_mode, .fail_event, .fail_clear,
	.shared_fail_pin_a_out, .shared_fail_pin_a_oe_n,
	.shared_fail_pin_b_strap_out, .shared_fail_pin_b_strap_oe_n,
	.static_fail_n, .wake_en_a, .wake_en_b);

// >>> tb/fga_loads.sv
// External loads and wake sources on the two shared pins.
`timescale 1ns/10ps
module fga_loads
(
	input wire logic a_out,
	input wire logic a_oe_n,
	input wire logic b_out,
	input wire logic b_oe_n,
	input wire logic src_a,
	input wire logic src_b,
	input wire logic power_up,
	output logic pin_a,
	output logic pin_b
);
	// A released pin follows its wake source, which always drives a level.
	assign pin_a = !a_oe_n ? a_out : src_a;
	// Pin b is held high during power-up to keep the strap out of test use.
	assign pin_b = power_up ? 1'b1 : (!b_oe_n ? b_out : src_b);
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the fail output and general pin block.
`timescale 1ns/10ps
module testbench
	import fga_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [2:0] chip_mode = 3'h0;
	logic fail_event = 1'b0;
	logic fail_clear = 1'b0;
	logic src_a = 1'b1;
	logic src_b = 1'b1;
	logic pin_a, pin_b, a_out, a_oe_n, b_out, b_oe_n;
	logic static_fail_n, wake_en_a, wake_en_b, strap_level;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;

	always #5 clk = ~clk;

	fga_top #(.BLINK_CYC(40), .PWM_CYC(40), .STRAP_CYC(8)) dut (.clk, .rst,
		.avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .chip_mode,
		.fail_event, .fail_clear, .shared_fail_pin_a_in(pin_a),
		.shared_fail_pin_a_out(a_out), .shared_fail_pin_a_oe_n(a_oe_n),
		.shared_fail_pin_b_strap_in(pin_b),
		.shared_fail_pin_b_strap_out(b_out),
		.shared_fail_pin_b_strap_oe_n(b_oe_n), .static_fail_n, .wake_en_a,
		.wake_en_b, .strap_level);
	fga_loads loads (.a_out, .a_oe_n, .b_out, .b_oe_n, .src_a, .src_b,
		.power_up(rst), .pin_a, .pin_b);

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task test_done;
		$display("errors %0d, comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task wr(input logic [2:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest)
			@(posedge clk);
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task rd(input logic [2:0] a, input logic [31:0] exp);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest)
			@(posedge clk);
		avs_read <= 1'b0;
		chk(avs_readdata, exp);
		@(posedge clk);
	endtask

	task pulse_clear;
		fail_clear <= 1'b1;
		@(posedge clk);
		fail_clear <= 1'b0;
		tick(3);
	endtask

	// Counts the cycles of the first low phase a pin shows.
	task automatic lowlen(input bit b, output int n);
		int k;
		n = 0;
		k = 0;
		while ((b ? pin_b : pin_a) && k < 100)
		begin
			@(posedge clk);
			k++;
		end
		while (!(b ? pin_b : pin_a) && n < 100)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	task t_reset;
		rd(REG_CFG, 32'h0);
		rd(REG_DUTY, 32'h0);
		rd(REG_STAT, 32'h2);
		rd(3'h7, 32'h0);
		chk(32'({a_oe_n, b_oe_n, static_fail_n}), 32'h7);
	endtask

	task t_fail(input logic [1:0] code, input int plen);
		int na, nb;
		wr(REG_DUTY, {30'h0, code});
		chip_mode <= MODE_RESTART;
		fail_event <= 1'b1;
		@(posedge clk);
		fail_event <= 1'b0;
		fork
			lowlen(1'b0, na);
			lowlen(1'b1, nb);
			begin
				tick(2);
				chk(32'({static_fail_n, a_oe_n, b_oe_n}), 0);
			end
		join
		chk(32'(na), 32'd20);
		chk(32'(nb), 32'(plen));
		chk(32'(static_fail_n), 32'h0);
		chip_mode <= MODE_NORMAL;
		tick(3);
		chk(32'(static_fail_n), 32'h0);
		rd(REG_STAT, 32'h3);
		rd(REG_CFG, 32'h0);
		pulse_clear();
		chk(32'(static_fail_n), 32'h1);
	endtask

	task t_sw;
		wr(REG_CFG, 32'h62);
		tick(2);
		chk(32'({a_oe_n, a_out, b_oe_n, b_out}), 32'h1);
		chip_mode <= MODE_STOP;
		wr(REG_CFG, 32'h11);
		chk(32'({a_oe_n, a_out, b_oe_n, b_out}), 32'h1);
		rd(REG_CFG, 32'h62);
		rd(REG_LVL, 32'h2);
		rd(REG_STAT, 32'h2);
		chip_mode <= MODE_SLEEP;
		tick(2);
		chk(32'({a_oe_n, a_out, b_oe_n, b_out}), 32'h1);
		chip_mode <= MODE_RESTART;
		tick(2);
		chk(32'({a_oe_n, b_oe_n}), 32'h3);
		chip_mode <= MODE_NORMAL;
		tick(2);
		chk(32'({a_oe_n, a_out, b_oe_n, b_out}), 32'h1);
	endtask

	task t_wake;
		wr(REG_CFG, 32'h13);
		tick(2);
		chk(32'({wake_en_a, wake_en_b, b_oe_n}), 32'h5);
		wr(REG_WAKE, 32'h3);
		rd(REG_WAKE, 32'h0);
		src_a <= 1'b0;
		tick(3);
		rd(REG_WAKE, 32'h1);
		rd(REG_LVL, 32'h2);
		wr(REG_WAKE, 32'h1);
		rd(REG_WAKE, 32'h0);
		src_b <= 1'b0;
		tick(4);
		chk(32'(strap_level), 32'h1);
		tick(12);
		chk(32'(strap_level), 32'h0);
		rd(REG_LVL, 32'h0);
		src_b <= 1'b1;
		chip_mode <= MODE_RESTART;
		fail_event <= 1'b1;
		@(posedge clk);
		fail_event <= 1'b0;
		tick(4);
		chk(32'({wake_en_a, b_oe_n}), 32'h3);
		chip_mode <= MODE_FAILSAFE;
		tick(2);
		chk(32'(wake_en_a), 32'h0);
		chip_mode <= MODE_NORMAL;
		tick(2);
		chk(32'(wake_en_a), 32'h1);
		rd(REG_CFG, 32'h13);
		pulse_clear();
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_count++;
			test_done();
		end
	end

	initial
	begin
		tick(20);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		for (int i = 0; i < 4; i++)
			t_fail(2'(i), 8 >> i);
		t_sw();
		t_wake();
		test_done();
	end
endmodule
